// [hw/usb_global_control_pkg.sv]
// Package for the USB global control block: register map, field layout,
// timing constants and the carrier structs.
// Assumes a 250 MHz system clock and an APB slave with 32-bit data.
`default_nettype none

package usb_global_control_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] GLOBAL_CONTROL_ADDR = 8'hbc;
    localparam logic [7:0] DEVICE_ADDRESS_ADDR = 8'hc0;
    localparam logic [7:0] IRQ_STATUS_ADDR     = 8'hc4;
    localparam logic [7:0] IRQ_MASK_ADDR       = 8'hc8;

    // ------------------------------------------------------------------
    // Global control field positions
    // ------------------------------------------------------------------
    localparam int CTL_ENABLE      = 7;
    localparam int CTL_CLK_SUSPEND = 6;
    localparam int CTL_SEND_WAKE   = 5;
    localparam int CTL_DISCONNECT  = 4;
    localparam int CTL_UPRESUME    = 3;
    localparam int CTL_WAKE_ENABLE = 2;
    localparam int CTL_CONFIGURED  = 1;
    localparam int CTL_ADDR_ENABLE = 0;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [6:0] DEFAULT_ADDRESS = 7'h00;

    // ------------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------------
    localparam int IRQ_BUS_RESET  = 0;
    localparam int IRQ_RESUME_END = 1;
    localparam int IRQ_WIDTH      = 2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ        = 250;
    localparam int BUS_RESET_NS   = 2700;
    localparam int BUS_RESET_CYC  = (BUS_RESET_NS * CLK_MHZ + 999) / 1000;
    localparam int SUSPEND_MIN_MS = 5;
    localparam int SUSPEND_CYC    = SUSPEND_MIN_MS * CLK_MHZ * 1000;
    localparam int RESUME_MS      = 10;
    localparam int RESUME_CYC     = RESUME_MS * CLK_MHZ * 1000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic dp;
        logic dm;
    } usb_lines_s;

endpackage

`default_nettype wire

// [hw/usb_global_control.sv]
// Global control of a full-speed USB device controller: control register,
// address register, suspend clock gating, bus reset detect, upstream resume.
// Assumes line states arrive from pins (synchronised here) and that the
// controller core consumes the enables and address driven out.
`default_nettype none

module usb_global_control #(
    parameter int SUSPEND_CYCLES = usb_global_control_pkg::SUSPEND_CYC,
    parameter int RESUME_CYCLES  = usb_global_control_pkg::RESUME_CYC
) (
    // Clock and reset
    input  wire logic                               CLK,
    input  wire logic                               NRST,
    // APB slave
    input  wire usb_global_control_pkg::apb_req_s   APB_REQ,
    output logic                                    PREADY,
    output logic                                    PSLVERR,
    output logic [31:0]                             PRDATA,
    // USB line pins (asynchronous)
    input  wire usb_global_control_pkg::usb_lines_s LINES,
    input  wire logic                               BUS_SUSPENDED,
    // Controller side
    output logic                                    CORE_ENABLE,
    output logic                                    CORE_RESET,
    output logic                                    USB_CLK_ENABLE,
    output logic                                    RESUME_DETECT_ON,
    output logic                                    WAKE_REQUEST,
    output logic                                    DRIVE_RESUME,
    output logic                                    VREF_OUT,
    output logic                                    VREF_OE_N,
    output logic [6:0]                              FUNCTION_ADDRESS,
    output logic                                    ADDRESS_FILTER_ON,
    output logic                                    CONFIGURED,
    // Interrupt
    output logic                                    IRQ
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  dp_sync;
        logic [1:0]  dm_sync;
        logic [1:0]  susp_sync;
        logic [7:0]  control;
        logic        filter_on;
        logic [6:0]  address;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [31:0] se0_count;
        logic [31:0] susp_count;
        logic [31:0] resume_count;
        logic        resuming;
        logic        wake_prev;
        logic [31:0] rdata;
    } state_s;

    state_s st;
    state_s next_st;

    // ------------------------------------------------------------------
    // Integration notes
    // ------------------------------------------------------------------
    // Register access
    // - Zero wait states; PRDATA is registered from the setup address,
    //   so it already stands when the access phase is sampled.
    // - Only the low byte of each word is used; upper bits read zero.
    // - Unmapped offsets read zero and ignore writes, without an error,
    //   so a stray access cannot stall the bus.
    // - The upstream resume flag is owned by hardware: software writes
    //   to that bit are dropped.
    //
    // Line side
    // - Both line pins and the suspend level cross two flip-flops
    //   before use, which adds two cycles to every detect latency.
    // - Bus reset needs an unbroken SE0 run; a single J cycle restarts
    //   the count, so glitches on an idle bus cannot clear state.
    // - The SE0 count saturates, giving one pulse per reset however
    //   long the host holds SE0.
    //
    // Suspend and resume
    // - The suspend counter also saturates, so a long suspend cannot
    //   wrap it back under the threshold.
    // - Resume starts only on a fresh rising edge of send wake; a bit
    //   left set from an earlier attempt never retriggers by itself.
    //   Software must clear it and set it again once conditions hold.
    // - Resume length is fixed by RESUME_CYCLES; the flag clears by
    //   itself and a status event marks the end.
    // - Clock suspend only requests the gate; the gate itself lives in
    //   the clock tree, outside this block.
    //
    // Disable and bus_disconnect_cmd
    // - Clearing the enable bit aborts any resume in progress, holds
    //   the core in reset and floats the pull-up reference.
    // - Bus_disconnect_cmd floats the pull-up as well; the host sees a disconnect.
    //
    // Interrupts
    // - Status bits are sticky; a read of the status word clears them.
    // - An event in the same cycle as that read survives the clear, but one
    //   raised in the setup cycle before it is cleared without being read.
    // - IRQ is a level, high while any unmasked status bit is set.

    logic access;
    logic wr;
    logic rd;
    logic se0;
    logic bus_reset;
    logic suspended_long;
    logic clocks_on;
    logic wake_rise;
    logic [1:0] events;

    always_comb
    begin
        next_st = st;
        access  = APB_REQ.psel & APB_REQ.penable;
        wr      = access & APB_REQ.pwrite;
        rd      = access & ~APB_REQ.pwrite;

        // Two-stage synchronisers; only stage 2 is read by logic
        next_st.dp_sync   = {st.dp_sync[0], LINES.dp};
        next_st.dm_sync   = {st.dm_sync[0], LINES.dm};
        next_st.susp_sync = {st.susp_sync[0], BUS_SUSPENDED};

        // --------------------------------------------------------------
        // Bus reset detect
        // --------------------------------------------------------------
        se0 = ~st.dp_sync[1] & ~st.dm_sync[1];
        if (se0 && st.control[usb_global_control_pkg::CTL_ENABLE])
        begin
            if (st.se0_count < 32'(usb_global_control_pkg::BUS_RESET_CYC))
                next_st.se0_count = st.se0_count + 32'h1;
        end
        else
            next_st.se0_count = 32'h0;
        // One pulse when the SE0 run reaches 2.7 us
        bus_reset = se0 && st.control[usb_global_control_pkg::CTL_ENABLE]
            && (st.se0_count
                == 32'(usb_global_control_pkg::BUS_RESET_CYC) - 32'h1);

        // --------------------------------------------------------------
        // Suspend duration and upstream resume
        // --------------------------------------------------------------
        if (st.susp_sync[1])
        begin
            if (st.susp_count < 32'(SUSPEND_CYCLES))
                next_st.susp_count = st.susp_count + 32'h1;
        end
        else
            next_st.susp_count = 32'h0;
        suspended_long = st.susp_count >= 32'(SUSPEND_CYCLES);
        clocks_on = ~st.control[usb_global_control_pkg::CTL_CLK_SUSPEND];
        wake_rise = st.control[usb_global_control_pkg::CTL_SEND_WAKE]
            & ~st.wake_prev;
        next_st.wake_prev = st.control[usb_global_control_pkg::CTL_SEND_WAKE];
        events = '0;

        if (st.resuming)
        begin
            if (st.resume_count == 32'h0)
            begin
                next_st.resuming = 1'b0;
                next_st.control[usb_global_control_pkg::CTL_UPRESUME] =
                    1'b0;
                events[usb_global_control_pkg::IRQ_RESUME_END] = 1'b1;
            end
            else
                next_st.resume_count = st.resume_count - 32'h1;
        end
        else if (wake_rise
            && st.control[usb_global_control_pkg::CTL_WAKE_ENABLE]
            && clocks_on && suspended_long)
        begin
            next_st.resuming     = 1'b1;
            next_st.resume_count = 32'(RESUME_CYCLES) - 32'h1;
            next_st.control[usb_global_control_pkg::CTL_UPRESUME] =
                1'b1;
        end

        // --------------------------------------------------------------
        // Register writes (send wake is never self-cleared)
        // --------------------------------------------------------------
        if (wr)
        begin
            unique case (APB_REQ.paddr)
                usb_global_control_pkg::GLOBAL_CONTROL_ADDR:
                begin
                    // Flag bit is hardware owned; keep any set this cycle
                    next_st.control = {APB_REQ.pwdata[7:4],
                        next_st.control[usb_global_control_pkg::CTL_UPRESUME],
                        APB_REQ.pwdata[2:0]};
                end
                usb_global_control_pkg::DEVICE_ADDRESS_ADDR:
                begin
                    next_st.filter_on = APB_REQ.pwdata[7];
                    next_st.address   = APB_REQ.pwdata[6:0];
                end
                usb_global_control_pkg::IRQ_MASK_ADDR:
                    next_st.mask = APB_REQ.pwdata[1:0];
                default:
                    next_st.rdata = st.rdata;
            endcase
        end

        // Bus reset wins over software writes of the state bits
        if (bus_reset)
        begin
            next_st.control[usb_global_control_pkg::CTL_CONFIGURED]  =
                1'b0;
            next_st.control[usb_global_control_pkg::CTL_ADDR_ENABLE] =
                1'b0;
            next_st.address = usb_global_control_pkg::DEFAULT_ADDRESS;
            events[usb_global_control_pkg::IRQ_BUS_RESET] = 1'b1;
        end

        // Disabled controller drops the resume flag and any resume in progress
        if (!next_st.control[usb_global_control_pkg::CTL_ENABLE])
        begin
            next_st.control[usb_global_control_pkg::CTL_UPRESUME] = 1'b0;
            next_st.resuming = 1'b0;
        end

        // --------------------------------------------------------------
        // Read data and interrupt status (set beats read-clear)
        // --------------------------------------------------------------
        next_st.rdata = 32'h0;
        unique case (APB_REQ.paddr)
            usb_global_control_pkg::GLOBAL_CONTROL_ADDR:
                next_st.rdata = {24'h0, st.control};
            usb_global_control_pkg::DEVICE_ADDRESS_ADDR:
                next_st.rdata = {24'h0, st.filter_on, st.address};
            usb_global_control_pkg::IRQ_STATUS_ADDR:
                next_st.rdata = {30'h0, st.status};
            usb_global_control_pkg::IRQ_MASK_ADDR:
                next_st.rdata = {30'h0, st.mask};
            default:
                next_st.rdata = 32'h0;
        endcase
        if (rd && APB_REQ.paddr == usb_global_control_pkg::IRQ_STATUS_ADDR)
            next_st.status = events;
        else
            next_st.status = st.status | events;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset clears everything: the core starts disabled and held in
    // reset, the pull-up floats, and the address falls back to the
    // default, so the device stays invisible until software enables it.
    // Only constants appear in the reset branch.
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st         <= '0;
            st.control <= usb_global_control_pkg::CONTROL_RESET;
            st.address <= usb_global_control_pkg::DEFAULT_ADDRESS;
        end
        else
            st <= next_st;
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output below is a plain decode of registered state, so none
    // of them can glitch on an input change within a cycle.
    // VREF_OUT is a constant high; the enable and disconnect bits decide whether the
    // pull-up reference is driven or left floating.
    // FUNCTION_ADDRESS shows the default address until software enables
    // the assigned one, so early packets still reach address zero.
    //
    // Zero wait states: read data is precomputed during the setup cycle
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA  = st.rdata;
    assign CORE_ENABLE = st.control[usb_global_control_pkg::CTL_ENABLE];
    assign CORE_RESET  = ~st.control[usb_global_control_pkg::CTL_ENABLE];
    // Clock gate request; resume detect stays alive while gated
    assign USB_CLK_ENABLE = st.control[usb_global_control_pkg::CTL_ENABLE]
        & ~st.control[usb_global_control_pkg::CTL_CLK_SUSPEND];
    assign RESUME_DETECT_ON = st.control[usb_global_control_pkg::CTL_ENABLE];
    assign WAKE_REQUEST = st.control[usb_global_control_pkg::CTL_SEND_WAKE]
        & st.control[usb_global_control_pkg::CTL_ENABLE];
    assign DRIVE_RESUME = st.resuming;
    assign VREF_OUT  = 1'b1;
    // Floated when detached or disabled, which releases the bus
    assign VREF_OE_N = st.control[usb_global_control_pkg::CTL_DISCONNECT]
        | ~st.control[usb_global_control_pkg::CTL_ENABLE];
    assign FUNCTION_ADDRESS =
        st.control[usb_global_control_pkg::CTL_ADDR_ENABLE]
        ? st.address : usb_global_control_pkg::DEFAULT_ADDRESS;
    assign ADDRESS_FILTER_ON = st.filter_on;
    assign CONFIGURED = st.control[usb_global_control_pkg::CTL_CONFIGURED];
    assign IRQ = |(st.status & st.mask);

endmodule

`default_nettype wire

// [tb/usb_global_control_sva.sv]
// Port-level checker for the USB global control block.
// Bound to the top module by the bench; sees only its ports.
`default_nettype none
module usb_global_control_sva #(
    parameter int SUSPEND_CYCLES = 20,
    parameter int RESUME_CYCLES  = 10
) (
    // Clock, reset and APB
    input wire logic                               CLK, NRST, PREADY, PSLVERR,
    input wire usb_global_control_pkg::apb_req_s   APB_REQ,
    input wire logic [31:0]                        PRDATA,
    // Line side and controller side
    input wire usb_global_control_pkg::usb_lines_s LINES,
    input wire logic                   BUS_SUSPENDED, CORE_ENABLE, CORE_RESET,
    input wire logic                   USB_CLK_ENABLE, RESUME_DETECT_ON,
    input wire logic                   WAKE_REQUEST, DRIVE_RESUME, VREF_OUT,
    input wire logic                   VREF_OE_N, ADDRESS_FILTER_ON,
    input wire logic [6:0]             FUNCTION_ADDRESS,
    input wire logic                   CONFIGURED, IRQ
);
    // Raw SE0 length; the block adds sync and detect latency on top
    wire         se0 = !LINES.dp && !LINES.dm && CORE_ENABLE;
    wire         wr  = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
    int unsigned se0_len;
    int unsigned hi_len;
    always_ff @(posedge CLK or negedge NRST)
        if (!NRST)
        begin
            se0_len <= 0;
            hi_len  <= 0;
        end
        else
        begin
            se0_len <= se0 ? se0_len + 1 : 0;
            hi_len  <= DRIVE_RESUME ? hi_len + 1 : 0;
        end
    default clocking dc @(posedge CLK); endclocking
    default disable iff (!NRST);
    property p_off; !CORE_ENABLE |-> CORE_RESET && VREF_OE_N
        && !DRIVE_RESUME && !WAKE_REQUEST; endproperty
    a_off: assert property (p_off) else $error("disabled core active");
    property p_vref; !VREF_OE_N |-> CORE_ENABLE && VREF_OUT; endproperty
    a_vref: assert property (p_vref) else $error("pull-up driven");
    property p_gate; CORE_ENABLE && !USB_CLK_ENABLE |-> RESUME_DETECT_ON;
    endproperty
    a_gate: assert property (p_gate) else $error("resume detect off");
    property p_rsm; $rose(DRIVE_RESUME) |-> $past(USB_CLK_ENABLE)
        && $past(BUS_SUSPENDED) && WAKE_REQUEST; endproperty
    a_rsm: assert property (p_rsm) else $error("resume not allowed");
    property p_len; hi_len <= RESUME_CYCLES; endproperty
    a_len: assert property (p_len) else $error("resume too long");
    property p_wake; $fell(WAKE_REQUEST) |-> $past(wr) || $past(wr, 2);
    endproperty
    a_wake: assert property (p_wake) else $error("wake self-cleared");
    property p_brst; se0_len == 700 |-> !CONFIGURED
        && FUNCTION_ADDRESS == 7'h00; endproperty
    a_brst: assert property (p_brst) else $error("bus reset missed");
    property p_apb; APB_REQ.psel && APB_REQ.penable |-> PREADY && !PSLVERR;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer wrong");
    c_rsm: cover property ($rose(DRIVE_RESUME));
    c_brst: cover property (se0_len == 700);
    c_irq: cover property ($rose(IRQ));
endmodule
`default_nettype wire

// [tb/usb_host_model.sv]
// Behavioural upstream host: line pair and suspend state.
// Assumes the bench asks for SE0 and suspend by levels.
`default_nettype none
module usb_host_model (
    // Clock and commands
    input  wire logic                              clk,
    input  wire logic                              se0_req,
    input  wire logic                              suspend_req,
    // Bus toward the device
    output var usb_global_control_pkg::usb_lines_s lines,
    output var logic                               bus_suspended
);
    initial
    begin
        lines         = 2'b10;
        bus_suspended = 1'b0;
    end
    // Idle is full-speed J, never left floating
    always @(posedge clk)
    begin
        lines.dp      <= !se0_req;
        lines.dm      <= 1'b0;
        bus_suspended <= suspend_req && !se0_req;
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench for the USB global control block: APB register tests with a
// behavioural host on the lines. Assumes the zero-wait APB slave.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    num_errors++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int         susp  = 20;
    localparam int         res   = 10;
    localparam logic [7:0] ctl_a = usb_global_control_pkg::GLOBAL_CONTROL_ADDR;
    localparam logic [7:0] adr_a = usb_global_control_pkg::DEVICE_ADDRESS_ADDR;
    localparam logic [7:0] sts_a = usb_global_control_pkg::IRQ_STATUS_ADDR;
    localparam logic [7:0] msk_a = usb_global_control_pkg::IRQ_MASK_ADDR;
    logic        clk = 1'b0, nrst = 1'b0, se0_req = 1'b0, suspend_req = 1'b0;
    logic        pready, pslverr, core_en, core_rst, clk_en, det_on, wake;
    logic        drive, vref, vref_oe_n, faddr_on, configured_flag, irq, bus_susp;
    logic [6:0]  faddr;
    logic [31:0] prdata;
    int          num_errors = 0, check_count = 0, cycles = 0;
    usb_global_control_pkg::apb_req_s   req = '0;
    usb_global_control_pkg::usb_lines_s lines;
    usb_global_control #(.SUSPEND_CYCLES(susp), .RESUME_CYCLES(res))
    usb_global_control_i (.CLK(clk), .NRST(nrst), .APB_REQ(req),
        .PREADY(pready), .PSLVERR(pslverr), .PRDATA(prdata), .LINES(lines),
        .BUS_SUSPENDED(bus_susp), .CORE_ENABLE(core_en), .CORE_RESET(core_rst),
        .USB_CLK_ENABLE(clk_en), .RESUME_DETECT_ON(det_on),
        .WAKE_REQUEST(wake), .DRIVE_RESUME(drive), .VREF_OUT(vref),
        .VREF_OE_N(vref_oe_n), .FUNCTION_ADDRESS(faddr),
        .ADDRESS_FILTER_ON(faddr_on), .CONFIGURED(configured_flag), .IRQ(irq));
    usb_host_model usb_host_model_i (.clk(clk), .se0_req(se0_req),
        .suspend_req(suspend_req), .lines(lines), .bus_suspended(bus_susp));
    always #2 clk = ~clk;
    task automatic end_of_test();
        $display("errors %0d, checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hung handshake lands here instead of spinning forever
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        req <= '0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input string n, input logic [7:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        `CHK(n, e, q)
    endtask
    task automatic se0(input int n);
        se0_req <= 1'b1;
        repeat (n) @(posedge clk);
        se0_req <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK("core_reset", 1'b1, core_rst)
        rd("control", ctl_a, 32'h0);
        rd("unmapped", 8'hd0, 32'h0);
        wr(ctl_a, 32'h80);
        `CHK("core_enable", 1'b1, core_en)
        `CHK("vref_oe_n", 1'b0, vref_oe_n)
        wr(ctl_a, 32'hc0);
        `CHK("usb_clk", 1'b0, clk_en)
        `CHK("resume_det", 1'b1, det_on)
        wr(ctl_a, 32'h90);
        `CHK("usb_clk", 1'b1, clk_en)
        `CHK("vref_oe_n", 1'b1, vref_oe_n)
        wr(adr_a, 32'h85);
        wr(ctl_a, 32'h82);
        `CHK("faddr", 7'h00, faddr)
        wr(ctl_a, 32'h8b);
        `CHK("faddr", 7'h05, faddr)
        rd("control", ctl_a, 32'h83);
        wr(ctl_a, 32'h81);
        `CHK("configured", 1'b0, configured_flag)
        wr(ctl_a, 32'h83);
        wr(msk_a, 32'h0);
        se0(300);
        `CHK("configured", 1'b1, configured_flag)
        se0(720);
        `CHK("configured", 1'b0, configured_flag)
        `CHK("irq", 1'b0, irq)
        rd("control", ctl_a, 32'h80);
        wr(ctl_a, 32'h81);
        `CHK("faddr", 7'h00, faddr)
        wr(msk_a, 32'h3);
        `CHK("irq", 1'b1, irq)
        rd("status", sts_a, 32'h1);
        `CHK("irq", 1'b0, irq)
        wr(ctl_a, 32'ha0);
        `CHK("wake_req", 1'b1, wake)
        rd("control", ctl_a, 32'ha0);
        suspend_req <= 1'b1;
        wr(ctl_a, 32'h84);
        wr(ctl_a, 32'ha4);
        `CHK("drive_resume", 1'b0, drive)
        wr(ctl_a, 32'h84);
        repeat (susp + 10) @(posedge clk);
        wr(ctl_a, 32'ha4);
        `CHK("drive_resume", 1'b1, drive)
        rd("control", ctl_a, 32'hac);
        repeat (res + 2) @(posedge clk);
        `CHK("drive_resume", 1'b0, drive)
        rd("control", ctl_a, 32'ha4);
        `CHK("irq", 1'b1, irq)
        rd("status", sts_a, 32'h2);
        end_of_test();
    end
endmodule
bind usb_global_control usb_global_control_sva #(
    .SUSPEND_CYCLES(SUSPEND_CYCLES), .RESUME_CYCLES(RESUME_CYCLES))
    usb_global_control_sva_i (.CLK, .NRST, .APB_REQ, .PREADY, .PSLVERR,
    .PRDATA, .LINES, .BUS_SUSPENDED, .CORE_ENABLE, .CORE_RESET,
    .USB_CLK_ENABLE, .RESUME_DETECT_ON, .WAKE_REQUEST, .DRIVE_RESUME,
    .VREF_OUT, .VREF_OE_N, .FUNCTION_ADDRESS, .ADDRESS_FILTER_ON,
    .CONFIGURED, .IRQ);
`default_nettype wire
